// [design/iusr_regs.sv]
// Integer unit special state registers and four hardware watchpoints.
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Behaviour
// - High word takes the upper product word of every multiply or step.
// - Divides take the upper dividend word from the high word register.
// - High word is read and written by its own instructions in any mode.
// - Trap base field is the top 20 bits of the trap table address.
// - Trap type is written on each trap except external reset, then held.
// - Trap type selects the entry offset within the trap table.
// - Trap base register is reached only by privileged instructions.
// - Window invalid mask is reached only by privileged instructions.
// - Program counter holds the address of the executing instruction.
// - Trap saves PC into local 1; trap return reloads PC from it.
// - Next PC holds the following instruction address absent a trap.
// - Trap saves next PC into local 2; trap return reloads it.
// - Four watchpoints: address at even ancillary 24-30, mask at odd 25-31.
// - Upper 30 bits of each address register hold the watched word address.
// - Fetch enable in the address register makes fetches hit.
// - Mask bit one compares that address bit; zero ignores it.
// - Load enable in the mask register makes loads hit.
// - Store enable in the mask register makes stores hit.
// - Watchpoint registers use ancillary instructions in any mode.
// - Registers read safely after power-up; unreset bits may be undefined.
// ----------------------------------------------------------------------
module iusr_regs
	import iusr_pkg::*;
#(
	parameter int NUM_WATCH = IUSR_NUM_WATCH,
	parameter int NUM_WIN   = IUSR_NUM_WIN
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Special register access from the pipeline
	input  wire logic        supervisor,
	input  wire logic        rd_en,
	input  wire logic        wr_en,
	input  wire iusr_sel_t   reg_sel,
	input  wire logic [4:0]  asr_num,
	input  wire logic [31:0] wr_data,
	output logic      [31:0] rd_data,
	output logic             priv_fault,
	// Multiply and divide unit
	input  wire logic        mul_done,
	input  wire logic [31:0] mul_high,
	output logic      [31:0] div_high,
	// Program flow
	input  wire logic        advance,
	input  wire logic [31:0] target_pc,
	input  wire logic        trap_take,
	input  wire logic        trap_ext_reset,
	input  wire logic [7:0]  trap_type_in,
	input  wire logic        trap_return,
	input  wire logic [31:0] saved_pc,
	input  wire logic [31:0] saved_npc,
	output logic      [31:0] trap_vector,
	output logic      [31:0] pc_out,
	output logic      [31:0] npc_out,
	output logic      [31:0] save_local1,
	output logic      [31:0] save_local2,
	// Watchpoint compare
	input  wire logic        acc_fetch,
	input  wire logic        acc_load,
	input  wire logic        acc_store,
	input  wire logic [31:0] fetch_addr,
	input  wire logic [31:0] data_addr,
	output logic             watch_hit
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	// Data words carry no reset, so they read safely but undefined.
	logic [31:0]          mdh_q;
	logic [31:0]          mdh_d;
	logic [19:0]          tba_q;
	logic [19:0]          tba_d;
	logic [7:0]           code_q;
	logic [7:0]           code_d;
	logic [NUM_WIN-1:0]   winmask_q;
	logic [NUM_WIN-1:0]   winmask_d;
	logic [31:0]          pc_q;
	logic [31:0]          pc_d;
	logic [31:0]          npc_q;
	logic [31:0]          npc_d;
	logic [29:0]          waddr_q [NUM_WATCH];
	logic [29:0]          waddr_d [NUM_WATCH];
	logic [29:0]          wmask_q [NUM_WATCH];
	logic [29:0]          wmask_d [NUM_WATCH];
	logic [NUM_WATCH-1:0] fen_q;
	logic [NUM_WATCH-1:0] fen_d;
	logic [NUM_WATCH-1:0] len_q;
	logic [NUM_WATCH-1:0] len_d;
	logic [NUM_WATCH-1:0] sen_q;
	logic [NUM_WATCH-1:0] sen_d;
	logic [NUM_WATCH-1:0] fetch_hits;
	logic [NUM_WATCH-1:0] data_hits;
	logic [31:0]          entry_vec;
	logic                 priv_sel;
	logic                 acc_ok;
	logic                 wr_ok;
	logic                 asr_watch;
	logic [1:0]           widx;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Word compare under a mask, shared by the fetch and the data path.
	function automatic logic addr_match(input logic [29:0] a, input logic [29:0] w,
			input logic [29:0] m);
		addr_match = (((a ^ w) & m) == 30'h0);
	endfunction : addr_match

	// Trap table entry: base on top, trap code as the entry offset.
	function automatic logic [31:0] table_entry(input logic [19:0] base,
			input logic [7:0] code);
		table_entry = {base, code, IUSR_VEC_PAD};
	endfunction : table_entry

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	assign priv_sel   = (reg_sel == IUSR_SEL_TRAP_BASE) || (reg_sel == IUSR_SEL_WIN_MASK);
	assign acc_ok     = !priv_sel || supervisor;
	assign wr_ok      = wr_en && acc_ok;
	assign priv_fault = (rd_en || wr_en) && !acc_ok;
	assign asr_watch  = (reg_sel == IUSR_SEL_ASR) && (asr_num >= IUSR_ASR_WATCH_FIRST)
			&& (asr_num <= IUSR_ASR_WATCH_LAST);
	assign widx       = asr_num[2:1];

	tbr_priv_a : assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && reg_sel == IUSR_SEL_TRAP_BASE && !supervisor)
		|-> (priv_fault && rd_data == 32'h0000_0000))
		else $error("User read of trap base allowed");

	win_priv_a : assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && reg_sel == IUSR_SEL_WIN_MASK && !supervisor) |-> priv_fault)
		else $error("User access to window mask");

	asr_user_a : assert property (@(posedge clk) disable iff (!rst_n)
		((rd_en || wr_en) && reg_sel == IUSR_SEL_ASR) |-> !priv_fault)
		else $error("Ancillary access refused");

	// ---------------------------------------------------------------
	// Multiply and divide high word
	// ---------------------------------------------------------------
	always_comb begin
		mdh_d = mdh_q;
		if (wr_ok && (reg_sel == IUSR_SEL_MDH)) begin
			mdh_d = wr_data;
		end
		// The product lands last, so it wins over a write in the same cycle.
		if (mul_done) begin
			mdh_d = mul_high;
		end
	end

	always_ff @(posedge clk) begin
		mdh_q <= mdh_d;
	end

	mdh_from_mul_a : assert property (@(posedge clk) disable iff (!rst_n)
		mul_done |=> (mdh_q == $past(mul_high)))
		else $error("High word missed product");

	mdh_write_a : assert property (@(posedge clk) disable iff (!rst_n)
		(wr_en && reg_sel == IUSR_SEL_MDH && !mul_done) |=> (mdh_q == $past(wr_data)))
		else $error("High word write lost");

	mdh_read_a : assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && reg_sel == IUSR_SEL_MDH) |-> (rd_data == mdh_q && !priv_fault))
		else $error("High word read wrong");

	mdh_div_link_a : assert property (@(posedge clk) disable iff (!rst_n)
		div_high == mdh_q)
		else $error("Divide high word wrong");

	// ---------------------------------------------------------------
	// Trap base and trap code
	// ---------------------------------------------------------------
	always_comb begin
		tba_d  = tba_q;
		code_d = code_q;
		if (wr_ok && (reg_sel == IUSR_SEL_TRAP_BASE)) begin
			tba_d = wr_data[31:IUSR_TBA_LSB];
		end
		// An external reset trap leaves the last trap code in place.
		if (trap_take && !trap_ext_reset) begin
			code_d = trap_type_in;
		end
	end

	always_ff @(posedge clk) begin
		tba_q  <= tba_d;
		code_q <= code_d;
	end

	code_keep_a : assert property (@(posedge clk) disable iff (!rst_n)
		!trap_take |=> $stable(code_q))
		else $error("Trap code changed");

	code_ext_a : assert property (@(posedge clk) disable iff (!rst_n)
		(trap_take && trap_ext_reset) |=> $stable(code_q))
		else $error("Trap code written on reset trap");

	code_write_a : assert property (@(posedge clk) disable iff (!rst_n)
		(trap_take && !trap_ext_reset)
		|=> (trap_vector[IUSR_TBA_LSB-1:IUSR_CODE_LSB] == $past(trap_type_in)))
		else $error("Trap code not the table offset");

	base_priv_a : assert property (@(posedge clk) disable iff (!rst_n)
		(wr_en && reg_sel == IUSR_SEL_TRAP_BASE && !supervisor) |=> $stable(tba_q))
		else $error("User write to trap base");

	base_write_a : assert property (@(posedge clk) disable iff (!rst_n)
		(wr_en && reg_sel == IUSR_SEL_TRAP_BASE && supervisor)
		|=> (trap_vector[31:IUSR_TBA_LSB] == $past(wr_data[31:IUSR_TBA_LSB])))
		else $error("Trap base not on top of vector");

	// ---------------------------------------------------------------
	// Window invalid mask
	// ---------------------------------------------------------------
	always_comb begin
		winmask_d = winmask_q;
		if (wr_ok && (reg_sel == IUSR_SEL_WIN_MASK)) begin
			winmask_d = wr_data[NUM_WIN-1:0];
		end
	end

	always_ff @(posedge clk) begin
		winmask_q <= winmask_d;
	end

	win_write_a : assert property (@(posedge clk) disable iff (!rst_n)
		(wr_en && reg_sel == IUSR_SEL_WIN_MASK && supervisor)
		|=> (winmask_q == $past(wr_data[NUM_WIN-1:0])))
		else $error("Window mask write lost");

	// ---------------------------------------------------------------
	// Program counters
	// ---------------------------------------------------------------
	// The entry uses code_d: the new trap code, or the held one on an external reset trap.
	assign entry_vec = table_entry(tba_q, code_d);

	always_comb begin
		pc_d  = pc_q;
		npc_d = npc_q;
		if (trap_take) begin
			pc_d  = entry_vec;
			npc_d = entry_vec + IUSR_PC_STEP;
		end else if (trap_return) begin
			pc_d  = saved_pc;
			npc_d = saved_npc;
		end else if (advance) begin
			pc_d  = npc_q;
			npc_d = target_pc;
		end
	end

	always_ff @(posedge clk) begin
		pc_q  <= pc_d;
		npc_q <= npc_d;
	end

	trap_entry_a : assert property (@(posedge clk) disable iff (!rst_n)
		(trap_take && !(wr_en && reg_sel == IUSR_SEL_TRAP_BASE))
		|=> (pc_q == trap_vector && npc_q == trap_vector + IUSR_PC_STEP))
		else $error("Trap did not enter the table");

	rett_pc_a : assert property (@(posedge clk) disable iff (!rst_n)
		(trap_return && !trap_take) |=> (pc_q == $past(saved_pc)))
		else $error("Trap return PC reload wrong");

	rett_npc_a : assert property (@(posedge clk) disable iff (!rst_n)
		(trap_return && !trap_take) |=> (npc_q == $past(saved_npc)))
		else $error("Trap return next PC reload wrong");

	pc_step_a : assert property (@(posedge clk) disable iff (!rst_n)
		(advance && !trap_take && !trap_return) |=> (pc_q == $past(npc_q)))
		else $error("PC did not follow next PC");

	npc_step_a : assert property (@(posedge clk) disable iff (!rst_n)
		(advance && !trap_take && !trap_return) |=> (npc_q == $past(target_pc)))
		else $error("Next PC did not take the target");

	// ---------------------------------------------------------------
	// Watchpoint registers
	// ---------------------------------------------------------------
	always_comb begin
		waddr_d = waddr_q;
		wmask_d = wmask_q;
		fen_d   = fen_q;
		len_d   = len_q;
		sen_d   = sen_q;
		if (wr_ok && asr_watch) begin
			if (!asr_num[0]) begin
				waddr_d[widx] = wr_data[31:IUSR_WADDR_LSB];
				fen_d[widx]   = wr_data[IUSR_FETCH_BIT];
			end else begin
				wmask_d[widx] = wr_data[31:IUSR_WADDR_LSB];
				len_d[widx]   = wr_data[IUSR_LOAD_BIT];
				sen_d[widx]   = wr_data[IUSR_STORE_BIT];
			end
		end
		// Only the enables reset; address and mask keep whatever they hold.
		if (!rst_n) begin
			fen_d = {NUM_WATCH{IUSR_ENABLE_RST}};
			len_d = {NUM_WATCH{IUSR_ENABLE_RST}};
			sen_d = {NUM_WATCH{IUSR_ENABLE_RST}};
		end
	end

	always_ff @(posedge clk) begin
		waddr_q <= waddr_d;
		wmask_q <= wmask_d;
		fen_q   <= fen_d;
		len_q   <= len_d;
		sen_q   <= sen_d;
	end

	waddr_write_a : assert property (@(posedge clk) disable iff (!rst_n)
		(wr_en && reg_sel == IUSR_SEL_ASR && asr_num == IUSR_ASR_WATCH_FIRST)
		|=> (waddr_q[0] == $past(wr_data[31:IUSR_WADDR_LSB])))
		else $error("Watch address write lost");

	en_reset_a : assert property (@(posedge clk)
		$rose(rst_n) |-> (fen_q == '0 && len_q == '0 && sen_q == '0))
		else $error("Enables not cleared");

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		if (rd_en && acc_ok) begin
			unique case (reg_sel)
				IUSR_SEL_MDH:       rd_data = mdh_q;
				IUSR_SEL_TRAP_BASE: rd_data = table_entry(tba_q, code_q);
				IUSR_SEL_WIN_MASK:  rd_data = {{(32-NUM_WIN){1'b0}}, winmask_q};
				IUSR_SEL_PC:        rd_data = pc_q;
				IUSR_SEL_NPC:       rd_data = npc_q;
				IUSR_SEL_ASR: begin
					if (asr_watch && !asr_num[0]) begin
						rd_data = {waddr_q[widx], 1'b0, fen_q[widx]};
					end else if (asr_watch) begin
						rd_data = {wmask_q[widx], len_q[widx], sen_q[widx]};
					end
				end
				default: ;
			endcase
		end
	end

	pc_read_a : assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && reg_sel == IUSR_SEL_PC) |-> (rd_data == pc_out))
		else $error("PC read wrong");

	npc_read_a : assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && reg_sel == IUSR_SEL_NPC) |-> (rd_data == npc_out))
		else $error("Next PC read wrong");

	addr_reserved_a : assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && asr_watch && !asr_num[0]) |-> (rd_data[1] == 1'b0))
		else $error("Reserved address bit not zero");

	// ---------------------------------------------------------------
	// Hit compare
	// ---------------------------------------------------------------
	// Hit is combinational so the pipeline can trap on the same access.
	always_comb begin
		fetch_hits = '0;
		data_hits  = '0;
		for (int i = 0; i < NUM_WATCH; i++) begin
			fetch_hits[i] = acc_fetch && fen_q[i]
					&& addr_match(fetch_addr[31:2], waddr_q[i], wmask_q[i]);
			data_hits[i]  = ((acc_load && len_q[i]) || (acc_store && sen_q[i]))
					&& addr_match(data_addr[31:2], waddr_q[i], wmask_q[i]);
		end
	end

	assign watch_hit = |{fetch_hits, data_hits};

	no_hit_a : assert property (@(posedge clk) disable iff (!rst_n)
		(fen_q == '0 && len_q == '0 && sen_q == '0) |-> !watch_hit)
		else $error("Hit while disabled");

	fetch_hit_a : assert property (@(posedge clk) disable iff (!rst_n)
		(acc_fetch && fen_q[0] && ((fetch_addr[31:2] ^ waddr_q[0]) & wmask_q[0]) == 30'h0)
		|-> watch_hit)
		else $error("Fetch hit missed");

	mask_ignore_a : assert property (@(posedge clk) disable iff (!rst_n)
		(acc_fetch && fen_q[0] && wmask_q[0] == 30'h0) |-> watch_hit)
		else $error("Zero mask still compared");

	load_off_a : assert property (@(posedge clk) disable iff (!rst_n)
		(acc_load && !acc_fetch && !acc_store && len_q == '0) |-> !watch_hit)
		else $error("Load hit while disabled");

	store_off_a : assert property (@(posedge clk) disable iff (!rst_n)
		(acc_store && !acc_fetch && !acc_load && sen_q == '0) |-> !watch_hit)
		else $error("Store hit while disabled");

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign div_high    = mdh_q;
	assign trap_vector = table_entry(tba_q, code_q);
	assign pc_out      = pc_q;
	assign npc_out     = npc_q;
	assign save_local1 = pc_q;
	assign save_local2 = npc_q;

endmodule : iusr_regs

// [design/iusr_pkg.sv]
// Package of constants for the integer unit state and watchpoint registers.
package iusr_pkg;

	// ---------------------------------------------------------------
	// Register selection codes
	// ---------------------------------------------------------------
	localparam logic [4:0] IUSR_ASR_WATCH_FIRST = 5'h18;
	localparam logic [4:0] IUSR_ASR_WATCH_LAST  = 5'h1F;

	// ---------------------------------------------------------------
	// Field layout
	// ---------------------------------------------------------------
	localparam int IUSR_TBA_LSB   = 12;
	localparam int IUSR_CODE_LSB  = 4;
	localparam int IUSR_WADDR_LSB = 2;
	localparam int IUSR_FETCH_BIT = 0;
	localparam int IUSR_LOAD_BIT  = 1;
	localparam int IUSR_STORE_BIT = 0;
	localparam int IUSR_NUM_WATCH = 4;
	localparam int IUSR_NUM_WIN   = 8;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic IUSR_ENABLE_RST = 1'b0;

	// ---------------------------------------------------------------
	// Program flow
	// ---------------------------------------------------------------
	localparam logic [31:0] IUSR_PC_STEP = 32'h0000_0004;
	localparam logic [3:0]  IUSR_VEC_PAD = 4'h0;

	// ---------------------------------------------------------------
	// Special register selector
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		IUSR_SEL_MDH       = 3'h0,
		IUSR_SEL_TRAP_BASE = 3'h1,
		IUSR_SEL_WIN_MASK  = 3'h3,
		IUSR_SEL_PC        = 3'h2,
		IUSR_SEL_NPC       = 3'h6,
		IUSR_SEL_ASR       = 3'h7
	} iusr_sel_t;

endpackage : iusr_pkg

// [verification/iusr_flow_model.sv]
// Pipeline-side model: sequential fetch stream and trap local registers.
`timescale 1ns/10ps
module iusr_flow_model (
	// Clock
	input  wire logic        clk,
	// Trap strobe, and outputs of the register block
	input  wire logic        trap_take,
	input  wire logic [31:0] npc_out,
	input  wire logic [31:0] save_local1,
	input  wire logic [31:0] save_local2,
	// To the register block
	output logic      [31:0] target_pc,
	output logic      [31:0] saved_pc,
	output logic      [31:0] saved_npc
);
	// No branches are modelled, so the stream is strictly sequential.
	assign target_pc = npc_out + 32'h4;
	always @(posedge clk) begin
		if (trap_take) begin
			saved_pc  <= save_local1;
			saved_npc <= save_local2;
		end
	end
endmodule : iusr_flow_model

// [verification/tb_top.sv]
// Self-checking testbench for the state and watchpoint register block.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import iusr_pkg::*;
	logic        clk = 0, rst_n = 0, supervisor = 0, rd_en = 0, wr_en = 0;
	logic        mul_done = 0, advance = 0, trap_take = 0, trap_ext_reset = 0;
	logic        trap_return = 0, acc_fetch = 0, acc_load = 0, acc_store = 0;
	iusr_sel_t   reg_sel = IUSR_SEL_MDH;
	logic [4:0]  asr_num = 5'h0;
	logic [7:0]  trap_type_in = 8'h0;
	logic [31:0] wr_data = 0, mul_high = 0, fetch_addr = 0, data_addr = 0;
	logic [31:0] rd_data, div_high, target_pc, saved_pc, saved_npc, trap_vector;
	logic [31:0] pc_out, npc_out, save_local1, save_local2, a;
	logic        priv_fault, watch_hit;
	int          err_count = 0, checks = 0;
	logic [4:0]  k;

	always #4 clk = ~clk;

	iusr_regs i_iusr_regs (.clk(clk), .rst_n(rst_n), .supervisor(supervisor),
		.rd_en(rd_en), .wr_en(wr_en), .reg_sel(reg_sel), .asr_num(asr_num),
		.wr_data(wr_data), .rd_data(rd_data), .priv_fault(priv_fault),
		.mul_done(mul_done), .mul_high(mul_high), .div_high(div_high),
		.advance(advance), .target_pc(target_pc), .trap_take(trap_take),
		.trap_ext_reset(trap_ext_reset), .trap_type_in(trap_type_in),
		.trap_return(trap_return), .saved_pc(saved_pc), .saved_npc(saved_npc),
		.trap_vector(trap_vector), .pc_out(pc_out), .npc_out(npc_out),
		.save_local1(save_local1), .save_local2(save_local2),
		.acc_fetch(acc_fetch), .acc_load(acc_load), .acc_store(acc_store),
		.fetch_addr(fetch_addr), .data_addr(data_addr), .watch_hit(watch_hit));

	iusr_flow_model i_iusr_flow_model (.clk(clk), .trap_take(trap_take),
		.npc_out(npc_out), .save_local1(save_local1), .save_local2(save_local2),
		.target_pc(target_pc), .saved_pc(saved_pc), .saved_npc(saved_npc));

	// ---------------------------------------------------------------
	// Bus and event tasks
	// ---------------------------------------------------------------
	task automatic wr(input iusr_sel_t s, input logic [4:0] n, input logic [31:0] d,
		input logic f);
		@(negedge clk);
		reg_sel = s;
		asr_num = n;
		wr_data = d;
		wr_en   = 1'b1;
		#1 `CHK(priv_fault, f)
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr

	task automatic rd(input iusr_sel_t s, input logic [4:0] n, input logic [31:0] e,
		input logic f);
		@(negedge clk);
		reg_sel = s;
		asr_num = n;
		rd_en   = 1'b1;
		#1 `CHK(rd_data, e)
		`CHK(priv_fault, f)
		@(negedge clk);
		rd_en = 1'b0;
	endtask : rd

	// Access stays asserted until the next call changes it.
	task automatic acc(input logic f, l, s, input logic [31:0] ad, input logic e);
		@(negedge clk);
		acc_fetch  = f;
		acc_load   = l;
		acc_store  = s;
		fetch_addr = ad;
		data_addr  = ad;
		#1 `CHK(watch_hit, e)
	endtask : acc

	task automatic flow(input logic t, x, r, v, input logic [7:0] code,
		input logic [31:0] p, np);
		@(negedge clk);
		trap_take      = t;
		trap_ext_reset = x;
		trap_return    = r;
		advance        = v;
		trap_type_in   = code;
		@(negedge clk);
		{trap_take, trap_ext_reset, trap_return, advance} = 4'h0;
		`CHK(pc_out, p)
		`CHK(npc_out, np)
	endtask : flow

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_y;
		wr(IUSR_SEL_MDH, 5'h0, 32'h1234_5678, 1'b0);
		rd(IUSR_SEL_MDH, 5'h0, 32'h1234_5678, 1'b0);
		`CHK(div_high, 32'h1234_5678)
		@(negedge clk);
		mul_done = 1'b1;
		mul_high = 32'hCAFE_F00D;
		wr_en    = 1'b1;
		@(negedge clk);
		mul_done = 1'b0;
		wr_en    = 1'b0;
		rd(IUSR_SEL_MDH, 5'h0, 32'hCAFE_F00D, 1'b0);
	endtask : t_y

	task automatic t_trap;
		supervisor = 1'b1;
		wr(IUSR_SEL_TRAP_BASE, 5'h0, 32'hABCD_E000, 1'b0);
		flow(1, 0, 0, 0, 8'h5A, 32'hABCD_E5A0, 32'hABCD_E5A4);
		`CHK(trap_vector, 32'hABCD_E5A0)
		rd(IUSR_SEL_TRAP_BASE, 5'h0, 32'hABCD_E5A0, 1'b0);
		flow(0, 0, 0, 1, 8'h0, 32'hABCD_E5A4, 32'hABCD_E5A8);
		flow(1, 1, 0, 0, 8'h11, 32'hABCD_E5A0, 32'hABCD_E5A4);
		flow(0, 0, 0, 1, 8'h0, 32'hABCD_E5A4, 32'hABCD_E5A8);
		flow(0, 0, 0, 1, 8'h0, 32'hABCD_E5A8, 32'hABCD_E5AC);
		flow(0, 0, 1, 0, 8'h0, 32'hABCD_E5A4, 32'hABCD_E5A8);
		wr(IUSR_SEL_WIN_MASK, 5'h0, 32'h0000_00A5, 1'b0);
		rd(IUSR_SEL_WIN_MASK, 5'h0, 32'h0000_00A5, 1'b0);
		supervisor = 1'b0;
		wr(IUSR_SEL_TRAP_BASE, 5'h0, 32'h1111_1000, 1'b1);
		rd(IUSR_SEL_TRAP_BASE, 5'h0, 32'h0, 1'b1);
		wr(IUSR_SEL_WIN_MASK, 5'h0, 32'h1, 1'b1);
		rd(IUSR_SEL_WIN_MASK, 5'h0, 32'h0, 1'b1);
		supervisor = 1'b1;
		rd(IUSR_SEL_TRAP_BASE, 5'h0, 32'hABCD_E5A0, 1'b0);
		rd(IUSR_SEL_WIN_MASK, 5'h0, 32'h0000_00A5, 1'b0);
		rd(IUSR_SEL_PC, 5'h0, 32'hABCD_E5A4, 1'b0);
		rd(IUSR_SEL_NPC, 5'h0, 32'hABCD_E5A8, 1'b0);
		supervisor = 1'b0;
	endtask : t_trap

	task automatic t_watch;
		for (int n = 0; n < 4; n++) begin
			a = 32'h4000_0000 + 32'(n << 12);
			k = 5'h18 + 5'(2 * n);
			wr(IUSR_SEL_ASR, k, a | 32'h3, 1'b0);
			rd(IUSR_SEL_ASR, k, a | 32'h1, 1'b0);
			wr(IUSR_SEL_ASR, k + 5'h1, 32'hFFFF_FF02, 1'b0);
			rd(IUSR_SEL_ASR, k + 5'h1, 32'hFFFF_FF02, 1'b0);
			acc(1, 0, 0, a + 32'h3C, 1'b1);
			acc(1, 0, 0, a ^ 32'h100, 1'b0);
			acc(0, 1, 0, a + 32'h4, 1'b1);
			acc(0, 0, 1, a, 1'b0);
			wr(IUSR_SEL_ASR, k + 5'h1, 32'hFFFF_FF01, 1'b0);
			acc(0, 0, 1, a, 1'b1);
			acc(0, 1, 0, a, 1'b0);
			wr(IUSR_SEL_ASR, k, a, 1'b0);
			acc(1, 0, 0, a, 1'b0);
			acc(0, 0, 0, 32'h0, 1'b0);
		end
	endtask : t_watch

	task automatic wrap_up;
		if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		acc(1, 0, 0, 32'h0, 1'b0);
		acc(0, 1, 0, 32'h0, 1'b0);
		acc(0, 0, 1, 32'h0, 1'b0);
		t_y();
		t_trap();
		t_watch();
		// A second reset must drop the store watch left armed by the last pair.
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		acc(0, 0, 1, a, 1'b0);
		wrap_up();
	end

	// The whole run needs under 150 cycles; this cuts a hang short.
	initial begin
		#20000;
		err_count++;
		wrap_up();
	end
endmodule : tb_top
